// ==== common/ssp_pkg.sv ====
// constants and types for the flash sector protection block
package ssp_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W        = 25;
    localparam int SECTOR_W      = 13;
    localparam int BLOCK_W       = 9;
    localparam int SECTOR_LSB    = 12;
    localparam int BLOCK_LSB     = 16;
    localparam int NUM_BLOCKS    = 512;
    localparam int NUM_PARAM     = 32;
    localparam int PARAM_IDX_W   = 5;
    localparam int SECT_PER_B32  = 8;
    localparam int SECT_PER_B64  = 16;
    localparam logic [SECTOR_W-1:0] LAST_SECTOR = 13'h1FFF;
    localparam logic [ADDR_W-1:0]   STATION_WIRED_ADDR   = 25'h1FFF000;
    localparam logic [ADDR_W-1:0]   STATION_OPTICAL_ADDR = 25'h1FFF006;
    localparam int STATION_LEN   = 6;

    // ------------------------------------------------------------
    // reset values, as delivered
    // ------------------------------------------------------------
    localparam logic                  PLACE_RESET      = 1'h0;
    localparam logic [NUM_BLOCKS-1:0] BLOCK_LOCK_RESET = {1'h0, {(NUM_BLOCKS-1){1'h1}}};
    localparam logic [NUM_PARAM-1:0]  PARAM_LOCK_RESET = 32'h7FFFFFFF;
    localparam logic                  FAIL_FLAG_RESET  = 1'h0;
    localparam logic                  LOCK_STATE_RESET = 1'h1;

    // ------------------------------------------------------------
    // commands and transfer widths
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_PROGRAM    = 4'h0,
        OP_ERASE_4K   = 4'h1,
        OP_ERASE_32K  = 4'h2,
        OP_ERASE_64K  = 4'h3,
        OP_ERASE_CHIP = 4'h4,
        OP_LOCK_SET   = 4'h5,
        OP_LOCK_ERASE = 4'h6,
        OP_LOCK_READ  = 4'h7,
        OP_PLACE_PROG = 4'h8
    } ssp_op_type;

    typedef enum logic [1:0] {
        WIDTH_SINGLE = 2'h0,
        WIDTH_DUAL   = 2'h1,
        WIDTH_QUAD   = 2'h2
    } ssp_width_type;

    typedef struct packed {
        logic [NUM_BLOCKS-1:0] block_lock;
        logic [NUM_PARAM-1:0]  param_lock;
        logic                  place;
        logic                  ok;
        logic                  fail;
        logic                  fail_flag;
        logic                  lock_state;
    } ssp_state_type;

endpackage

// ==== verilog/ssp_protect.sv ====
// sector map and program/erase protection logic of the serial flash
`timescale 1ns/10ps
module ssp_protect (
    input  wire logic                        clk,          // 20 MHz clock
    input  wire logic                        srst,         // sync reset, high
    input  wire logic                        cmd_valid,    // command strobe
    input  wire logic [3:0]                  cmd_op,       // command code
    input  wire logic [1:0]                  cmd_width,    // line count code
    input  wire logic [ssp_pkg::ADDR_W-1:0]  cmd_addr,     // byte address
    input  wire logic                        cmd_data,     // placement bit value
    input  wire logic                        fail_clear,   // clear failure flag
    output logic                             rsp_ok,       // command done
    output logic                             rsp_fail,     // command refused
    output logic                             fail_flag,    // sticky failure
    output logic                             lock_state,   // lock bit read back
    output logic                             place_bit     // placement bit
);

    ssp_pkg::ssp_state_type cur;
    ssp_pkg::ssp_state_type nxt;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // sector carrying the two station addresses, never writable
    function automatic logic is_final(
        input logic [ssp_pkg::SECTOR_W-1:0] s
    );
        is_final = (s == ssp_pkg::LAST_SECTOR);
    endfunction

    // block holding a sector
    function automatic logic [ssp_pkg::BLOCK_W-1:0] block_of(
        input logic [ssp_pkg::SECTOR_W-1:0] s
    );
        block_of = s[ssp_pkg::SECTOR_W-1:ssp_pkg::BLOCK_LSB-ssp_pkg::SECTOR_LSB];
    endfunction

    // lock slot of a sector inside the parameter region
    function automatic logic [ssp_pkg::PARAM_IDX_W-1:0] param_of(
        input logic [ssp_pkg::SECTOR_W-1:0] s
    );
        param_of = s[ssp_pkg::PARAM_IDX_W-1:0];
    endfunction

    // only three line counts exist on the link
    function automatic logic width_legal(
        input logic [1:0] w
    );
        width_legal = (w == ssp_pkg::WIDTH_SINGLE) ||
                      (w == ssp_pkg::WIDTH_DUAL)   ||
                      (w == ssp_pkg::WIDTH_QUAD);
    endfunction

    // sectors that a program or erase code must find writable
    function automatic logic [4:0] span_of(
        input logic [3:0] op
    );
        case (op)
            ssp_pkg::OP_ERASE_32K: begin
                span_of = 5'(ssp_pkg::SECT_PER_B32);
            end
            ssp_pkg::OP_ERASE_64K: begin
                span_of = 5'(ssp_pkg::SECT_PER_B64);
            end
            default: begin
                span_of = 5'h01;
            end
        endcase
    endfunction

    // one-time programmable: a cleared placement bit never returns to 1
    function automatic logic place_allowed(
        input logic cur_place,
        input logic d
    );
        place_allowed = cur_place || !d;
    endfunction

    function automatic logic in_param(
        input logic                          place,
        input logic [ssp_pkg::SECTOR_W-1:0] s
    );
        // parameter region: two 64KB blocks at top or bottom
        if (place) begin
            in_param = (s[ssp_pkg::SECTOR_W-1:ssp_pkg::PARAM_IDX_W] == 8'h00);
        end else begin
            in_param = (s[ssp_pkg::SECTOR_W-1:ssp_pkg::PARAM_IDX_W] == 8'hFF);
        end
    endfunction

    function automatic logic sector_prot(
        input ssp_pkg::ssp_state_type       st,
        input logic [ssp_pkg::SECTOR_W-1:0] s
    );
        if (is_final(s)) begin
            sector_prot = 1'b1;
        end else if (in_param(st.place, s)) begin
            sector_prot = !st.param_lock[param_of(s)];
        end else begin
            sector_prot = !st.block_lock[block_of(s)];
        end
    endfunction

    // any protected sector inside an aligned span of n sectors
    function automatic logic span_prot(
        input ssp_pkg::ssp_state_type       st,
        input logic [ssp_pkg::SECTOR_W-1:0] s,
        input logic [4:0]                   n
    );
        logic [ssp_pkg::SECTOR_W-1:0] base;
        base = s & ~(ssp_pkg::SECTOR_W'(n) - 13'h0001);
        span_prot = 1'b0;
        for (int i = 0; i < ssp_pkg::SECT_PER_B64; i++) begin
            if (5'(i) < n) begin
                span_prot = span_prot | sector_prot(st, base + ssp_pkg::SECTOR_W'(i));
            end
        end
    endfunction

    // lock bits with the bit covering one sector cleared
    function automatic ssp_pkg::ssp_state_type lock_cleared(
        input ssp_pkg::ssp_state_type       st,
        input logic [ssp_pkg::SECTOR_W-1:0] s
    );
        lock_cleared = st;
        if (in_param(st.place, s)) begin
            lock_cleared.param_lock[param_of(s)] = 1'h0;
        end else begin
            lock_cleared.block_lock[block_of(s)] = 1'h0;
        end
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [ssp_pkg::SECTOR_W-1:0] sec;
    logic                         refuse;
    logic                         width_ok;

    // sector number from the 25-bit byte address
    assign sec = cmd_addr[ssp_pkg::ADDR_W-1:ssp_pkg::SECTOR_LSB];

    // one command a cycle; each sees the effects of the one before
    always_comb begin
        nxt        = cur;
        nxt.ok     = 1'b0;
        nxt.fail   = 1'b0;
        refuse     = 1'b0;
        width_ok   = width_legal(cmd_width);
        if (cmd_valid) begin
            if (!width_ok) begin
                refuse = 1'b1;
            end else begin
                case (cmd_op)
                    ssp_pkg::OP_PROGRAM,
                    ssp_pkg::OP_ERASE_4K,
                    ssp_pkg::OP_ERASE_32K,
                    ssp_pkg::OP_ERASE_64K: begin
                        // every sector of the aligned span must be writable
                        refuse = span_prot(cur, sec, span_of(cmd_op));
                    end
                    ssp_pkg::OP_ERASE_CHIP: begin
                        // final sector survives, so a chip erase never fully succeeds
                        refuse = 1'b1;
                    end
                    ssp_pkg::OP_LOCK_SET: begin
                        nxt = lock_cleared(nxt, sec);
                    end
                    ssp_pkg::OP_LOCK_ERASE: begin
                        // final sector stays refused whatever its lock reads
                        nxt.block_lock = '1;
                        nxt.param_lock = '1;
                    end
                    ssp_pkg::OP_LOCK_READ: begin
                        // 1 reads back as writable
                        nxt.lock_state = !sector_prot(cur, sec);
                    end
                    ssp_pkg::OP_PLACE_PROG: begin
                        if (place_allowed(cur.place, cmd_data)) begin
                            nxt.place = cmd_data;
                        end else begin
                            refuse = 1'b1;
                        end
                    end
                    default: begin
                        refuse = 1'b1;
                    end
                endcase
            end
            nxt.ok   = !refuse;
            nxt.fail = refuse;
        end
        // new failure wins over a clear in the same cycle
        nxt.fail_flag = (cur.fail_flag & !fail_clear) | refuse;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            cur.block_lock <= ssp_pkg::BLOCK_LOCK_RESET;
            cur.param_lock <= ssp_pkg::PARAM_LOCK_RESET;
            cur.place      <= ssp_pkg::PLACE_RESET;
            cur.ok         <= 1'h0;
            cur.fail       <= 1'h0;
            cur.fail_flag  <= ssp_pkg::FAIL_FLAG_RESET;
            cur.lock_state <= ssp_pkg::LOCK_STATE_RESET;
        end else begin
            cur <= nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every output straight from the state register
    assign rsp_ok     = cur.ok;
    assign rsp_fail   = cur.fail;
    assign fail_flag  = cur.fail_flag;
    assign lock_state = cur.lock_state;
    assign place_bit  = cur.place;

endmodule

// ==== test/ssp_protect_props.sv ====
// assertion checker for the sector protection block
`timescale 1ns/10ps
module ssp_protect_props (
    input wire logic                       clk,        // clock
    input wire logic                       srst,       // sync reset, high
    input wire logic                       cmd_valid,  // command strobe
    input wire logic                       cmd_data,   // placement value
    input wire logic                       fail_clear, // flag clear
    input wire logic [3:0]                 cmd_op,     // command code
    input wire logic [1:0]                 cmd_width,  // line count code
    input wire logic [ssp_pkg::ADDR_W-1:0] cmd_addr,   // byte address
    input wire logic                       rsp_ok,     // accepted
    input wire logic                       rsp_fail,   // refused
    input wire logic                       fail_flag,  // sticky failure
    input wire logic                       lock_state, // lock read back
    input wire logic                       place_bit   // placement bit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_final;
        cmd_valid && cmd_width != 2'h3 && cmd_addr[24:12] == ssp_pkg::LAST_SECTOR;
    endsequence
    AST_ONE_RSP: assert property (cmd_valid |=> rsp_ok != rsp_fail)
        else $error("not one answer");
    AST_IDLE: assert property (!cmd_valid |=> !rsp_ok && !rsp_fail)
        else $error("answer without command");
    AST_WIDTH: assert property (cmd_valid && cmd_width == 2'h3 |=> rsp_fail)
        else $error("bad width taken");
    AST_FINAL: assert property (s_final ##0 cmd_op <= 4'h4 |=> rsp_fail)
        else $error("final sector altered");
    AST_READ: assert property (s_final ##0 cmd_op == 4'h7 |=> rsp_ok && !lock_state)
        else $error("final sector unlocked");
    AST_STICKY: assert property (fail_flag && !fail_clear |=> fail_flag)
        else $error("flag lost");
    AST_SET: assert property (rsp_fail |-> fail_flag)
        else $error("flag not set");
    AST_OTP: assert property (!place_bit |=> !place_bit)
        else $error("placement restored");
    AST_HOLD: assert property (!(cmd_valid && cmd_op == 4'h7) |=> $stable(lock_state))
        else $error("lock state moved");
endmodule
bind ssp_protect ssp_protect_props ssp_protect_props_i (.clk(clk), .srst(srst),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .fail_clear(fail_clear), .cmd_op(cmd_op),
    .cmd_width(cmd_width), .cmd_addr(cmd_addr), .rsp_ok(rsp_ok), .rsp_fail(rsp_fail),
    .fail_flag(fail_flag), .lock_state(lock_state), .place_bit(place_bit));

// ==== test/ssp_host.sv ====
// flash controller model driving the command port
`timescale 1ns/10ps
module ssp_host (
    input  wire logic              clk,        // clock
    input  wire logic              rsp_ok,     // accept
    input  wire logic              rsp_fail,   // refuse
    output logic                   cmd_valid,  // strobe
    output logic [3:0]             cmd_op,     // code
    output logic [1:0]             cmd_width,  // lines
    output logic [24:0]            cmd_addr,   // address
    output logic                   cmd_data,   // value
    output logic                   fail_clear  // clear
);
    initial begin
        cmd_valid = 1'b0;
        cmd_op = 4'h0;
        cmd_width = 2'h0;
        cmd_addr = 25'h0;
        cmd_data = 1'b0;
        fail_clear = 1'b0;
    end
    task automatic send(input logic [3:0] op, input logic [1:0] w, input logic [24:0] a,
                        input logic d, input logic c, output logic ok, output logic fl);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_width = w;
        cmd_addr = a;
        cmd_data = d;
        fail_clear = c;
        @(negedge clk);
        ok = rsp_ok;
        fl = rsp_fail;
        cmd_valid = 1'b0;
        fail_clear = 1'b0;
        cmd_addr = ~a; // idle bus does not keep its value
        cmd_data = ~d;
    endtask
endmodule

// ==== test/test_ssp_protect.sv ====
// self-checking bench for the sector protection block
`timescale 1ns/10ps
module test_ssp_protect;
    logic        clk, srst, cmd_valid, cmd_data, fail_clear;
    logic [3:0]  cmd_op;
    logic [1:0]  cmd_width;
    logic [24:0] cmd_addr;
    logic        rsp_ok, rsp_fail, fail_flag, lock_state, place_bit;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          seed = 32'hE6F3;
    int          i;
    bit          blk [512];
    bit          prm [32];
    bit          mflag, mlock;
    ssp_protect ssp_protect_i (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_width(cmd_width), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .fail_clear(fail_clear), .rsp_ok(rsp_ok), .rsp_fail(rsp_fail),
        .fail_flag(fail_flag), .lock_state(lock_state), .place_bit(place_bit));
    ssp_host ssp_host_i (.clk(clk), .rsp_ok(rsp_ok), .rsp_fail(rsp_fail),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_width(cmd_width),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .fail_clear(fail_clear));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk; // 20 MHz
    end
    task automatic results;
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            results;
        end
    end
    task automatic check(input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: differs from model", $time);
        end
    endtask
    // parameter area stays at the top
    function automatic bit prot(int s);
        if (s == 8191) return 1'b1;
        if ((s >> 5) == 255) return !prm[s & 31];
        return !blk[s >> 4];
    endfunction
    task automatic cmd(int op, int w, int a, int d, int c);
        int   s;
        int   n;
        bit   bad;
        logic ok;
        logic fl;
        n = op == 2 ? 8 : op == 3 ? 16 : 1;
        s = (a >> 12) & ~(n - 1);
        bad = w == 3 || op == 4 || op > 8 || (op == 8 && d == 1);
        for (int k = 0; k < n; k++) bad |= op < 4 && prot(s + k);
        if (!bad && op == 5 && (s >> 5) == 255) prm[s & 31] = 1'b0;
        else if (!bad && op == 5) blk[s >> 4] = 1'b0;
        if (!bad && op == 6) prm = '{default: 1'b1};
        if (!bad && op == 6) blk = '{default: 1'b1};
        if (!bad && op == 7) mlock = !prot(s);
        mflag = bad || (mflag && !c);
        ssp_host_i.send(op[3:0], w[1:0], a[24:0], d[0], c[0], ok, fl);
        check(ok, !bad);
        check(fl, bad);
        check(fail_flag, mflag);
        check(lock_state, mlock);
        check(place_bit, 1'b0);
    endtask
    initial begin
        srst = 1'b1;
        mlock = 1'b1;
        mflag = 1'b0;
        prm = '{default: 1'b1};
        blk = '{default: 1'b1};
        prm[31] = 1'b0;
        blk[511] = 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        cmd(7, 0, ssp_pkg::STATION_WIRED_ADDR, 0, 0);
        for (i = 0; i < 5; i++) begin
            cmd(i, i % 3, ssp_pkg::STATION_WIRED_ADDR, 0, 0);
            cmd(i, 2, ssp_pkg::STATION_OPTICAL_ADDR, 0, 1);
        end
        cmd(8, 0, 0, 1, 0);
        cmd(8, 1, 0, 0, 1);
        cmd(6, 3, 0, 0, 0);
        // sweeps stay clear of the final sector
        for (i = 0; i < 400; i++)
            cmd({$random(seed)} % 10, {$random(seed)} % 4, ($random(seed) & 1) ?
                25'h1FE0000 + {$random(seed)} % 25'h1F000 : {$random(seed)} % 25'h20000,
                $random(seed) & 1, {$random(seed)} % 4 == 0);
        results;
    end
endmodule
